/* rtl/npic_pkg.sv */
package npic_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PRIO_VEC_0_3_OFS = 8'h1c;
	localparam logic [7:0] PRIO_VEC_4_7_OFS = 8'h1d;
	localparam logic [7:0] PRIO_VEC_8_11_OFS = 8'h1e;
	localparam logic [7:0] PRIO_VEC_12_13_OFS = 8'h1f;
	localparam logic [7:0] CC_FLAGS_OFS = 8'h20;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h21;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h22;
	localparam logic [7:0] CTRL_STATUS_OFS = 8'h23;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CUR_PRIO_HIGH_POS = 5;
	localparam int CUR_PRIO_LOW_POS = 3;
	localparam logic [7:0] CC_RESET = 8'hea;
	localparam logic [7:0] PRIO_REG_RESET = 8'hff;
	localparam logic [7:0] PRIO_REG3_RO_MASK = 8'hf0;
	localparam int NUM_PRIO_REGS = 4;
	localparam int NUM_MASKABLE = 14;
	localparam int NMI_INDEX = 0;
	localparam logic [3:0] VEC_RESET_IDX = 4'hf;
	localparam logic [3:0] VEC_TRAP_IDX = 4'he;
	localparam logic [15:0] VEC_TOP_ADDR = 16'hfffe;
	localparam logic [3:0] CPU_CLK_DIV = 4'h2;

	// ----------------------------------------------------------------
	// encodings of the current-priority pair
	// ----------------------------------------------------------------
	localparam logic [1:0] PAIR_LVL0 = 2'h2;
	localparam logic [1:0] PAIR_LVL1 = 2'h1;
	localparam logic [1:0] PAIR_LVL2 = 2'h0;
	localparam logic [1:0] PAIR_LVL3 = 2'h3;

	// status bit positions
	localparam int EV_MASKABLE = 0;
	localparam int EV_NONMASK = 1;
	localparam int EV_RETURN = 2;

	typedef enum logic [2:0] {
		NPIC_INS_NONE,
		NPIC_INS_ENABLE,
		NPIC_INS_DISABLE,
		NPIC_INS_HALT,
		NPIC_INS_WAIT,
		NPIC_INS_TRAP,
		NPIC_INS_RETURN,
		NPIC_INS_POPCC
	} npic_instr_t;

endpackage : npic_pkg

/* rtl/npic_nested_priority_interrupt_ctrl.sv */
`timescale 1ns/10ps
// Summary of operation
// - condition flags reset to 111x1010: upper ones, level 3, low pattern 1010
// - current pair at bits 5 and 3 encodes levels 0..3 as 10,01,00,11
// - entering a maskable vector loads the pair from its vector priority bits
// - reset, trap and nmi are serviced even at level 3
// - priority registers reset to ff; top nibble of the last reads one, read only
// - vector x owns pair in register x/4 at bits 2*(x mod 4)+1 and below
// - a written pair equal to level-0 pattern keeps its old value
// - servicing reset, trap or nmi sets the pair to level 3
// - nmi pair is read/writable but ignored by arbitration
// - priority change of serviced vector re-enters only if pending and higher
// - enable, halt and wait load 10; disable and trap load 11
// - priority set by an instruction holds until the next entry, return, popcc, flags write or such instruction
// - vectors fixed in falling hardware priority from reset down to i2c
// - after reset the cpu runs at oscillator divided by two
// - maskable request served only if enabled and above current level
// - highest software priority wins, ties broken by hardware priority
module npic_nested_priority_interrupt_ctrl (
	// clock and reset (ref_clk is the main oscillator)
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	// interrupt sources
	input wire logic [13:0] irqPending,
	input wire logic [13:0] irqEnable,
	input wire logic nmiReq,
	input wire logic resetReq,
	// cpu core side
	input wire logic [2:0] cpuInstr,
	input wire logic [7:0] stackedFlags,
	input wire logic entryAllowed,
	output logic entryValid,
	output logic [15:0] entryVector,
	output logic [3:0] entryIndex,
	output logic cpuClkEn,
	output logic [7:0] conditionCodeFlags,
	output logic irqOut
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// numeric rank: larger means more urgent
	function automatic logic [1:0] rankOf(input logic [1:0] pair);
		unique case (pair)
			npic_pkg::PAIR_LVL0: rankOf = 2'h0;
			npic_pkg::PAIR_LVL1: rankOf = 2'h1;
			npic_pkg::PAIR_LVL2: rankOf = 2'h2;
			npic_pkg::PAIR_LVL3: rankOf = 2'h3;
		endcase
	endfunction

	function automatic logic [7:0] ccWithPair(input logic [7:0] cc, input logic [1:0] pair);
		logic [7:0] r;
		r = cc;
		r[npic_pkg::CUR_PRIO_HIGH_POS] = pair[1];
		r[npic_pkg::CUR_PRIO_LOW_POS] = pair[0];
		return r;
	endfunction

	// write strobe decode, shared by every writable register
	function automatic logic wrHit(input logic stb, input logic [7:0] addr,
		input logic [7:0] ofs);
		return stb && (addr == ofs);
	endfunction

	// ----------------------------------------------------------------
	// cpu clock enable
	// ----------------------------------------------------------------
	logic [3:0] divCnt_q;
	logic cpuClkEn_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_q <= 4'h0;
			cpuClkEn_q <= 1'b0;
		end else begin
			// normal mode only: oscillator divided by two
			if (divCnt_q == npic_pkg::CPU_CLK_DIV - 4'h1) begin
				divCnt_q <= 4'h0;
				cpuClkEn_q <= 1'b1;
			end else begin
				divCnt_q <= divCnt_q + 4'h1;
				cpuClkEn_q <= 1'b0;
			end
		end
	end
	assign cpuClkEn = cpuClkEn_q;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [15:0] sync1_q;
	logic [15:0] sync2_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
		end else begin
			sync1_q <= {resetReq, nmiReq, irqPending};
			sync2_q <= sync1_q;
		end
	end
	logic [13:0] pendSync;
	logic nmiSync;
	logic rstReqSync;
	assign pendSync = sync2_q[13:0];
	assign nmiSync = sync2_q[14];
	assign rstReqSync = sync2_q[15];

	// nmi edge detector on the synchronised level
	logic nmiLast_q;
	logic nmiEdge;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmiLast_q <= 1'b0;
		end else begin
			nmiLast_q <= nmiSync;
		end
	end
	assign nmiEdge = nmiSync & ~nmiLast_q;

	// ----------------------------------------------------------------
	// vector priority registers
	// ----------------------------------------------------------------
	logic [7:0] prioReg_q [npic_pkg::NUM_PRIO_REGS];
	logic [1:0] vecPair [npic_pkg::NUM_MASKABLE];

	genvar gi;
	generate
		for (gi = 0; gi < npic_pkg::NUM_PRIO_REGS; gi++) begin : g_prio
			logic hit;
			logic [7:0] merged;
			assign hit = wrHit(regWrStb, regAddr, npic_pkg::PRIO_VEC_0_3_OFS + 8'(gi));
			always_comb begin
				merged = prioReg_q[gi];
				for (int p = 0; p < 4; p++) begin
					if (regWrData[2*p+1 -: 2] != npic_pkg::PAIR_LVL0) begin
						merged[2*p+1 -: 2] = regWrData[2*p+1 -: 2];
					end
				end
				if (gi == npic_pkg::NUM_PRIO_REGS - 1) begin
					merged = merged | npic_pkg::PRIO_REG3_RO_MASK;
				end
			end
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					prioReg_q[gi] <= npic_pkg::PRIO_REG_RESET;
				end else if (hit) begin
					prioReg_q[gi] <= merged;
				end
			end
		end
		for (gi = 0; gi < npic_pkg::NUM_MASKABLE; gi++) begin : g_pair
			assign vecPair[gi] = prioReg_q[gi/4][2*(gi%4)+1 -: 2];
		end
	endgenerate

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	logic [7:0] cc_q;
	logic [1:0] curPair;
	logic [1:0] curRank;
	assign curPair = {cc_q[npic_pkg::CUR_PRIO_HIGH_POS], cc_q[npic_pkg::CUR_PRIO_LOW_POS]};
	assign curRank = rankOf(curPair);

	logic winValid;
	logic [3:0] winIdx;
	logic [1:0] winRank;
	always_comb begin
		winValid = 1'b0;
		winIdx = 4'h0;
		winRank = 2'h0;
		// ascending index = descending hardware priority; strict > keeps earlier on ties
		for (int v = 1; v < npic_pkg::NUM_MASKABLE; v++) begin
			if (pendSync[v] && irqEnable[v]
				&& rankOf(vecPair[v]) > curRank) begin
				if (!winValid || rankOf(vecPair[v]) > winRank) begin
					winValid = 1'b1;
					winIdx = 4'(v);
					winRank = rankOf(vecPair[v]);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// entry sequencing and condition flags
	// ----------------------------------------------------------------
	// nmi latched until serviced; a fresh edge wins over the clear
	logic nmiPend_q;
	logic trapPend_q;
	logic entryValid_q;
	logic [15:0] entryVector_q;
	logic [3:0] entryIndex_q;
	logic takeEntry;
	npic_pkg::npic_instr_t instr;
	assign instr = npic_pkg::npic_instr_t'(cpuInstr);
	// entries are taken only on cpu clock enables, when the core says so
	assign takeEntry = cpuClkEn_q && entryAllowed;

	logic svcReset;
	logic svcTrap;
	logic svcNmi;
	logic svcMask;
	// reset, trap and nmi ignore the current level
	assign svcReset = takeEntry && rstReqSync;
	assign svcTrap = takeEntry && !svcReset && trapPend_q;
	assign svcNmi = takeEntry && !svcReset && !svcTrap && nmiPend_q;
	assign svcMask = takeEntry && !svcReset && !svcTrap && !svcNmi && winValid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmiPend_q <= 1'b0;
			trapPend_q <= 1'b0;
		end else begin
			nmiPend_q <= nmiEdge | (nmiPend_q & ~svcNmi);
			trapPend_q <= (instr == npic_pkg::NPIC_INS_TRAP) | (trapPend_q & ~svcTrap);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cc_q <= npic_pkg::CC_RESET;
		end else if (svcReset || svcTrap || svcNmi) begin
			cc_q <= ccWithPair(cc_q, npic_pkg::PAIR_LVL3);
		end else if (svcMask) begin
			// a reprioritised in-service vector re-enters only through this
			// path, so a lower new level never touches the pair
			cc_q <= ccWithPair(cc_q, vecPair[winIdx]);
		end else begin
			// pair set by an instruction stays until the next such change
			unique case (instr)
				npic_pkg::NPIC_INS_ENABLE, npic_pkg::NPIC_INS_HALT, npic_pkg::NPIC_INS_WAIT:
					cc_q <= ccWithPair(cc_q, npic_pkg::PAIR_LVL0);
				npic_pkg::NPIC_INS_DISABLE, npic_pkg::NPIC_INS_TRAP:
					cc_q <= ccWithPair(cc_q, npic_pkg::PAIR_LVL3);
				npic_pkg::NPIC_INS_RETURN, npic_pkg::NPIC_INS_POPCC:
					cc_q <= stackedFlags;
				npic_pkg::NPIC_INS_NONE: begin
					if (wrHit(regWrStb, regAddr, npic_pkg::CC_FLAGS_OFS)) begin
						cc_q <= regWrData;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			entryValid_q <= 1'b0;
			entryVector_q <= 16'h0000;
			entryIndex_q <= 4'h0;
		end else begin
			entryValid_q <= svcReset | svcTrap | svcNmi | svcMask;
			// vector address falls by two per step of hardware priority
			if (svcReset) begin
				entryIndex_q <= npic_pkg::VEC_RESET_IDX;
				entryVector_q <= npic_pkg::VEC_TOP_ADDR;
			end else if (svcTrap) begin
				entryIndex_q <= npic_pkg::VEC_TRAP_IDX;
				entryVector_q <= npic_pkg::VEC_TOP_ADDR - 16'h0002;
			end else if (svcNmi) begin
				entryIndex_q <= 4'h0;
				entryVector_q <= npic_pkg::VEC_TOP_ADDR - 16'h0004;
			end else if (svcMask) begin
				entryIndex_q <= winIdx;
				entryVector_q <= npic_pkg::VEC_TOP_ADDR - 16'h0004 - {11'h000, winIdx, 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// event status, mask and interrupt line
	// ----------------------------------------------------------------
	logic [2:0] evStatus_q;
	logic [2:0] evMask_q;
	logic irqOut_q;
	logic [2:0] evSet;
	assign evSet = {instr == npic_pkg::NPIC_INS_RETURN, svcReset | svcTrap | svcNmi, svcMask};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			evStatus_q <= 3'h0;
		end else if (wrHit(regWrStb, regAddr, npic_pkg::IRQ_STATUS_OFS)) begin
			// a new event in the clearing cycle survives
			evStatus_q <= (evStatus_q & ~regWrData[2:0]) | evSet;
		end else begin
			evStatus_q <= evStatus_q | evSet;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			evMask_q <= 3'h0;
		end else if (wrHit(regWrStb, regAddr, npic_pkg::IRQ_MASK_OFS)) begin
			evMask_q <= regWrData[2:0];
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqOut_q <= 1'b0;
		end else begin
			irqOut_q <= |(evStatus_q & evMask_q);
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	logic [7:0] rdData_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q <= 8'h00;
		end else if (regRdStb) begin
			unique case (regAddr)
				npic_pkg::PRIO_VEC_0_3_OFS: rdData_q <= prioReg_q[0];
				npic_pkg::PRIO_VEC_4_7_OFS: rdData_q <= prioReg_q[1];
				npic_pkg::PRIO_VEC_8_11_OFS: rdData_q <= prioReg_q[2];
				npic_pkg::PRIO_VEC_12_13_OFS: rdData_q <= prioReg_q[3];
				npic_pkg::CC_FLAGS_OFS: rdData_q <= cc_q;
				npic_pkg::IRQ_STATUS_OFS: rdData_q <= {5'h00, evStatus_q};
				npic_pkg::IRQ_MASK_OFS: rdData_q <= {5'h00, evMask_q};
				npic_pkg::CTRL_STATUS_OFS: rdData_q <= {nmiPend_q, trapPend_q, 2'h0, entryIndex_q};
				default: rdData_q <= 8'h00;
			endcase
		end else begin
			rdData_q <= 8'h00;
		end
	end

	assign regRdData = rdData_q;
	assign entryValid = entryValid_q;
	assign entryVector = entryVector_q;
	assign entryIndex = entryIndex_q;
	assign conditionCodeFlags = cc_q;
	assign irqOut = irqOut_q;

endmodule // npic_nested_priority_interrupt_ctrl

/* dv/npic_monitor.sv */
`timescale 1ns/10ps
module npic_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	// requests and core side
	input wire logic [13:0] irqEnable,
	input wire logic [2:0] cpuInstr,
	input wire logic [7:0] stackedFlags,
	input wire logic entryValid,
	input wire logic [15:0] entryVector,
	input wire logic [3:0] entryIndex,
	input wire logic cpuClkEn,
	input wire logic [7:0] conditionCodeFlags
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [13:0] enPrev_q;
	logic [7:0] cc;
	logic maskable;
	assign cc = conditionCodeFlags;
	assign maskable = entryIndex inside {[4'h1:4'hd]};
	// enable is unsynchronised, so the taking edge sees last cycle's value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			enPrev_q <= 14'h0000;
		else
			enPrev_q <= irqEnable;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	sequence clkGap;
		!cpuClkEn ##1 cpuClkEn;
	endsequence
	sequence insLow;
		(cpuInstr inside {3'h1, 3'h3, 3'h4}) ##1 !entryValid;
	endsequence
	sequence insHigh;
		(cpuInstr inside {3'h2, 3'h5}) ##1 !entryValid;
	endsequence
	sequence insPop;
		(cpuInstr inside {3'h6, 3'h7}) ##1 !entryValid;
	endsequence
	clk_half_a: assert property (cpuClkEn |=> clkGap)
		else $error("cpu clock enable not every second cycle");
	rd_idle_a: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
		else $error("read data outside read slot");
	rd_top_a: assert property (regRdStb && regAddr == 8'h1f |=> regRdData[7:4] == 4'hf)
		else $error("top nibble of last priority register not ones");
	ins_low_a: assert property (insLow |-> cc[5] && !cc[3])
		else $error("enable halt or wait did not load level 0");
	ins_high_a: assert property (insHigh |-> cc[5] && cc[3])
		else $error("disable or trap did not load level 3");
	ret_restore_a: assert property (insPop |-> cc == $past(stackedFlags))
		else $error("return did not restore stacked flags");
	nonmask_lvl_a: assert property (entryValid && !maskable |-> cc[5] && cc[3])
		else $error("non maskable entry not at level 3");
	vec_map_a: assert property (entryValid |-> entryVector == (entryIndex == 4'hf ? 16'hfffe :
		entryIndex == 4'he ? 16'hfffc : 16'hfffa - {11'h000, entryIndex, 1'h0}))
		else $error("entry vector does not match index");
	mask_en_a: assert property (entryValid && maskable |-> enPrev_q[entryIndex])
		else $error("disabled vector entered");
	entry_once_a: assert property (entryValid |=> !entryValid)
		else $error("entry pulse longer than one cycle");
endmodule // npic_monitor

bind npic_nested_priority_interrupt_ctrl npic_monitor u_npic_monitor (.ref_clk, .rst_n,
	.regAddr, .regRdStb, .regRdData, .irqEnable, .cpuInstr, .stackedFlags, .entryValid,
	.entryVector, .entryIndex, .cpuClkEn, .conditionCodeFlags);

/* dv/npic_core_model.sv */
`timescale 1ns/10ps
module npic_core_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// controller side
	input wire logic entryValid,
	input wire logic [2:0] cpuInstr,
	input wire logic [7:0] conditionCodeFlags,
	output logic entryAllowed,
	output logic [7:0] stackedFlags
);
	// ------------------------------------------------------------
	// busy window and flag stack
	// ------------------------------------------------------------
	logic [7:0] lastCc_q;
	logic [7:0] top_q;
	logic [7:0] deep_q;
	logic [2:0] hold_q;
	// refusing entries for a while after each one covers the request drop latency
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			hold_q <= 3'h0;
		else if (entryValid)
			hold_q <= 3'h6;
		else if (hold_q != 3'h0)
			hold_q <= hold_q - 3'h1;
	end
	assign entryAllowed = (hold_q == 3'h0);
	// two levels deep only: deeper nesting would lose the oldest flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastCc_q <= npic_pkg::CC_RESET;
			top_q <= npic_pkg::CC_RESET;
			deep_q <= npic_pkg::CC_RESET;
		end else if (entryValid) begin
			deep_q <= top_q;
			top_q <= lastCc_q;
		end else begin
			lastCc_q <= conditionCodeFlags;
			if (cpuInstr == 3'h6)
				top_q <= deep_q;
		end
	end
	assign stackedFlags = top_q;
endmodule // npic_core_model

/* dv/npic_nested_priority_interrupt_ctrl_tb_top.sv */
`timescale 1ns/10ps
module npic_nested_priority_interrupt_ctrl_tb_top;
	// ------------------------------------------------------------
	// stimulus, instances and tasks
	// ------------------------------------------------------------
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrStb = 1'h0;
	logic regRdStb = 1'h0;
	logic [13:0] irqPending = 14'h0000;
	logic [13:0] irqEnable = 14'h3fff;
	logic nmiReq = 1'h0;
	logic resetReq = 1'h0;
	logic [2:0] cpuInstr = 3'h0;
	logic [7:0] regRdData, stackedFlags, conditionCodeFlags;
	logic entryAllowed, entryValid, cpuClkEn, irqOut, irqA;
	logic [15:0] entryVector;
	logic [3:0] entryIndex;
	int numErrors = 0;
	int testsRun = 0;
	always #5 ref_clk = ~ref_clk;
	npic_nested_priority_interrupt_ctrl u_npic_nested_priority_interrupt_ctrl (.ref_clk,
		.rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .irqPending,
		.irqEnable, .nmiReq, .resetReq, .cpuInstr, .stackedFlags, .entryAllowed,
		.entryValid, .entryVector, .entryIndex, .cpuClkEn, .conditionCodeFlags, .irqOut);
	npic_core_model u_npic_core_model (.ref_clk, .rst_n, .entryValid, .cpuInstr,
		.conditionCodeFlags, .entryAllowed, .stackedFlags);
	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'h1;
		@(posedge ref_clk);
		regWrStb <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'h1;
		@(posedge ref_clk);
		regRdStb <= 1'h0;
		#1;
		chk({8'h00, regRdData}, {8'h00, e});
	endtask
	task automatic ins(input logic [2:0] c);
		@(posedge ref_clk);
		cpuInstr <= c;
		@(posedge ref_clk);
		cpuInstr <= 3'h0;
		#1;
	endtask
	task automatic waitEntry(input logic [3:0] i, input logic [15:0] v, input logic [7:0] c);
		int n;
		n = 0;
		// step off the edge so a pulse from the previous entry is not seen again
		#1;
		while (entryValid !== 1'h1) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 60) begin
				numErrors++;
				$display("[ERR] %0t no entry seen", $time);
				wrapUp();
			end
		end
		chk({12'h000, entryIndex}, {12'h000, i});
		chk(entryVector, v);
		chk({8'h00, conditionCodeFlags}, {8'h00, c});
	endtask
	initial begin
		logic [2:0] codes [4];
		logic [7:0] ccs [4];
		codes = '{3'h1, 3'h2, 3'h3, 3'h4};
		ccs = '{8'he2, 8'hea, 8'he2, 8'he2};
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int k = 0; k < 4; k++)
			rd(8'h1c + 8'(k), 8'hff);
		rd(8'h20, 8'hea);
		rd(8'h40, 8'h00);
		wr(8'h1c, 8'hcf);
		wr(8'h1c, 8'h64);
		rd(8'h1c, 8'h44);
		wr(8'h1f, 8'h00);
		rd(8'h1f, 8'hf0);
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			ins(codes[k]);
			chk({8'h00, conditionCodeFlags}, {8'h00, ccs[k]});
		end
		ins(3'h5);
		waitEntry(4'he, 16'hfffc, 8'hea);
		rd(8'h21, 8'h02);
		wr(8'h22, 8'h00);
		repeat (2) @(posedge ref_clk);
		#1 irqA = irqOut;
		wr(8'h22, 8'h02);
		repeat (2) @(posedge ref_clk);
		#1 chk({15'h0000, irqA ^ irqOut}, 16'h0001);
		wr(8'h21, 8'h02);
		rd(8'h21, 8'h00);
		chk({15'h0000, irqOut}, 16'h0000);
		$display("test instructions and status done");
		ins(3'h1);
		@(posedge ref_clk) irqPending <= 14'h000e;
		waitEntry(4'h2, 16'hfff6, 8'hc2);
		@(posedge ref_clk) irqPending <= 14'h000a;
		ins(3'h6);
		waitEntry(4'h1, 16'hfff8, 8'hca);
		@(posedge ref_clk) irqPending <= 14'h0008;
		ins(3'h6);
		waitEntry(4'h3, 16'hfff4, 8'hca);
		@(posedge ref_clk) irqPending <= 14'h0000;
		ins(3'h6);
		chk({8'h00, conditionCodeFlags}, 16'h00e2);
		rd(8'h21, 8'h05);
		$display("test nesting done");
		@(posedge ref_clk) irqEnable <= 14'h3fef;
		irqPending <= 14'h0010;
		repeat (20) @(posedge ref_clk);
		#1 chk({8'h00, conditionCodeFlags}, 16'h00e2);
		@(posedge ref_clk) irqEnable <= 14'h3fff;
		waitEntry(4'h4, 16'hfff2, 8'hea);
		@(posedge ref_clk) irqPending <= 14'h0000;
		nmiReq <= 1'h1;
		waitEntry(4'h0, 16'hfffa, 8'hea);
		@(posedge ref_clk) resetReq <= 1'h1;
		waitEntry(4'hf, 16'hfffe, 8'hea);
		@(posedge ref_clk) resetReq <= 1'h0;
		rd(8'h23, 8'h0f);
		$display("test non maskable done");
		wr(8'h20, 8'he2);
		rd(8'h20, 8'he2);
		ins(3'h7);
		chk({8'h00, conditionCodeFlags}, 16'h00ea);
		wr(8'h1d, 8'hf7);
		ins(3'h1);
		@(posedge ref_clk) irqPending <= 14'h0020;
		waitEntry(4'h5, 16'hfff0, 8'hca);
		wr(8'h1d, 8'hff);
		waitEntry(4'h5, 16'hfff0, 8'hea);
		wr(8'h1d, 8'hf7);
		repeat (10) @(posedge ref_clk);
		#1 chk({8'h00, conditionCodeFlags}, 16'h00ea);
		@(posedge ref_clk) irqPending <= 14'h0000;
		$display("test pop and re-entry done");
		wrapUp();
	end
endmodule // npic_nested_priority_interrupt_ctrl_tb_top
